// ### design/acf_formatter.sv
// Function
// - Main result is 32-bit two's complement, shifted out bit 31 first.
// - Zero main input yields all-zero 32-bit code.
// - Main code saturates at 7fffffff and 80000000.
// - Auxiliary code saturates at 7fffff and 800000.
// - Code step exponent equals word width: 32 main, 24 auxiliary.
// - Main result is four bytes, 31:24 first; read-only, zero after reset.
// - Auxiliary result is 24-bit two's complement, bit 23 first.
// - Zero auxiliary input yields all-zero 24-bit code.
// - Auxiliary bytes are followed by a zero pad byte before checksum.
// - Without status byte, data bytes move forward to lead the frame.
`timescale 1ns/1ns
`include "acf_defs.svh"
module acf_formatter #(
   parameter int ACC_W = `ACF_ACC_W
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic main_valid,
   input wire logic signed [ACC_W-1:0] main_raw,
   input wire logic aux_valid,
   input wire logic signed [ACC_W-1:0] aux_raw,
   input wire logic start,
   input wire acf_pkg::acf_sel_e sel,
   input wire logic status_en,
   input wire logic check_en,
   input wire logic [7:0] status_byte,
   input wire logic [7:0] check_byte,
   input wire logic shift,
   output logic sdo,
   output logic busy,
   output logic byte_last,
   output logic [`ACF_MAIN_W-1:0] main_word,
   output logic [`ACF_AUX_W-1:0] aux_word
);
   import acf_pkg::*;

   acf_state_e state;
   logic [7:0] sreg;
   logic [2:0] bit_cnt;
   logic [1:0] byte_idx;
   logic [`ACF_MAIN_W-1:0] frame_data;
   logic frame_aux;
   logic last_bit;
   logic [7:0] next_byte_data;
   logic [7:0] next_first;

   ////////////////////////////////////////////////////////////////////
   // Saturation: wide filter results are clamped to the word range
   function automatic logic [`ACF_MAIN_W-1:0] sat_main(
      input logic signed [ACC_W-1:0] v);
      logic signed [ACC_W-1:0] hi;
      logic signed [ACC_W-1:0] lo;
      hi = ACC_W'(signed'(`ACF_MAIN_MAX));
      lo = -hi - ACC_W'(1);
      if (v >= hi) sat_main = `ACF_MAIN_MAX;
      else if (v <= lo) sat_main = `ACF_MAIN_MIN;
      else sat_main = v[`ACF_MAIN_W-1:0];
   endfunction

   function automatic logic [`ACF_AUX_W-1:0] sat_aux(
      input logic signed [ACC_W-1:0] v);
      logic signed [ACC_W-1:0] hi;
      logic signed [ACC_W-1:0] lo;
      hi = ACC_W'(signed'({8'h00, `ACF_AUX_MAX}));
      lo = -hi - ACC_W'(1);
      if (v >= hi) sat_aux = `ACF_AUX_MAX;
      else if (v <= lo) sat_aux = `ACF_AUX_MIN;
      else sat_aux = v[`ACF_AUX_W-1:0];
   endfunction

   // Holding registers, read-only to the host, zero after reset
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         main_word <= `ACF_DATA_RST;
      end else if (main_valid) begin
         main_word <= sat_main(main_raw);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         aux_word <= `ACF_AUX_ZERO;
      end else if (aux_valid) begin
         aux_word <= sat_aux(aux_raw);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Byte sequencing. Data are snapshotted at start so a result update
   // mid-frame cannot tear the word; the full 32 bits always go out.
   assign last_bit = (bit_cnt == 3'h7);

   always_comb begin
      // Aux frame: three data bytes then the zero pad byte
      next_byte_data = frame_data[31-8*byte_idx-:8];
   end

   always_comb begin
      if (status_en) next_first = status_byte;
      else next_first = (sel == ACF_SEL_AUX) ? aux_word[23:16]
                                             : main_word[31:24];
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= ACF_ST_IDLE;
         sreg <= 8'h00;
         bit_cnt <= 3'h0;
         byte_idx <= 2'h0;
         frame_data <= `ACF_DATA_RST;
         frame_aux <= 1'b0;
      end else begin
         case (state)
            ACF_ST_IDLE: begin
               if (start) begin
                  frame_aux <= (sel == ACF_SEL_AUX);
                  frame_data <= (sel == ACF_SEL_AUX) ?
                     {aux_word, `ACF_PAD_BYTE} : main_word;
                  sreg <= next_first;
                  bit_cnt <= 3'h0;
                  byte_idx <= status_en ? 2'h0 : 2'h1;
                  state <= status_en ? ACF_ST_STATUS : ACF_ST_DATA;
               end
            end
            ACF_ST_STATUS, ACF_ST_DATA: begin
               if (shift) begin
                  sreg <= {sreg[6:0], 1'b0};
                  bit_cnt <= bit_cnt + 3'h1;
                  if (last_bit) begin
                     if (state == ACF_ST_STATUS) begin
                        sreg <= frame_data[31:24];
                        // Index 0 marks the final data byte, so skip it
                        byte_idx <= 2'h1;
                        state <= ACF_ST_DATA;
                     end else if (byte_idx == 2'h0) begin
                        if (check_en) begin
                           sreg <= check_byte;
                           state <= ACF_ST_CHECK;
                        end else begin
                           state <= ACF_ST_IDLE;
                        end
                     end else begin
                        sreg <= next_byte_data;
                        byte_idx <= byte_idx + 2'h1;
                     end
                  end
               end
            end
            ACF_ST_CHECK: begin
               if (shift) begin
                  sreg <= {sreg[6:0], 1'b0};
                  bit_cnt <= bit_cnt + 3'h1;
                  if (last_bit) state <= ACF_ST_IDLE;
               end
            end
            default: state <= ACF_ST_IDLE;
         endcase
      end
   end

   assign sdo = sreg[7];
   assign busy = (state != ACF_ST_IDLE);
   assign byte_last = busy && last_bit;

   ////////////////////////////////////////////////////////////////////
   property p_main_sat_hi;
      @(posedge clock) disable iff (!rst_n)
      main_valid && main_raw >= ACC_W'(signed'(`ACF_MAIN_MAX))
      |=> main_word == `ACF_MAIN_MAX;
   endproperty
   a_main_sat_hi: assert property (p_main_sat_hi)
      else $error("main high saturation wrong");

   property p_main_sat_lo;
      @(posedge clock) disable iff (!rst_n)
      main_valid && main_raw < -ACC_W'(signed'(`ACF_MAIN_MAX))
      |=> main_word == `ACF_MAIN_MIN;
   endproperty
   a_main_sat_lo: assert property (p_main_sat_lo)
      else $error("main low saturation wrong");

   property p_main_zero;
      @(posedge clock) disable iff (!rst_n)
      main_valid && main_raw == '0 |=> main_word == `ACF_MAIN_ZERO;
   endproperty
   a_main_zero: assert property (p_main_zero)
      else $error("main zero code wrong");

   property p_aux_sat;
      @(posedge clock) disable iff (!rst_n)
      aux_valid && aux_raw >= ACC_W'(signed'({8'h00, `ACF_AUX_MAX}))
      |=> aux_word == `ACF_AUX_MAX;
   endproperty
   a_aux_sat: assert property (p_aux_sat)
      else $error("aux saturation wrong");

   property p_aux_zero;
      @(posedge clock) disable iff (!rst_n)
      aux_valid && aux_raw == '0 |=> aux_word == `ACF_AUX_ZERO;
   endproperty
   a_aux_zero: assert property (p_aux_zero)
      else $error("aux zero code wrong");

   property p_first_msb;
      @(posedge clock) disable iff (!rst_n)
      state == ACF_ST_IDLE && start && !status_en && sel == ACF_SEL_MAIN
      |=> sdo == $past(main_word[31]);
   endproperty
   a_first_msb: assert property (p_first_msb)
      else $error("main msb not first");

   property p_aux_msb;
      @(posedge clock) disable iff (!rst_n)
      state == ACF_ST_IDLE && start && !status_en && sel == ACF_SEL_AUX
      |=> sdo == $past(aux_word[23]);
   endproperty
   a_aux_msb: assert property (p_aux_msb)
      else $error("aux msb not first");

   property p_pad;
      @(posedge clock) disable iff (!rst_n)
      state == ACF_ST_DATA && frame_aux && byte_idx == 2'h0
      && bit_cnt == 3'h0 |-> sreg == `ACF_PAD_BYTE;
   endproperty
   a_pad: assert property (p_pad)
      else $error("pad byte not zero");

   property p_status_to_data;
      @(posedge clock) disable iff (!rst_n)
      state == ACF_ST_STATUS && shift && last_bit
      |=> state == ACF_ST_DATA && byte_idx == 2'h1
      && sreg == frame_data[31:24];
   endproperty
   a_status_to_data: assert property (p_status_to_data)
      else $error("data does not follow status");

   property p_second_byte;
      @(posedge clock) disable iff (!rst_n)
      state == ACF_ST_DATA && shift && last_bit && byte_idx == 2'h1
      |=> sdo == frame_data[23];
   endproperty
   a_second_byte: assert property (p_second_byte)
      else $error("byte order wrong");
endmodule

// ### design/acf_defs.svh
`ifndef ACF_DEFS_SVH
`define ACF_DEFS_SVH
`define ACF_MAIN_W 32
`define ACF_AUX_W 24
`define ACF_MAIN_ZERO 32'h00000000
`define ACF_MAIN_MAX 32'h7fffffff
`define ACF_MAIN_MIN 32'h80000000
`define ACF_AUX_ZERO 24'h000000
`define ACF_AUX_MAX 24'h7fffff
`define ACF_AUX_MIN 24'h800000
`define ACF_PAD_BYTE 8'h00
`define ACF_DATA_RST 32'h00000000
`define ACF_ACC_W 40
`endif

// ### design/acf_pkg.sv
package acf_pkg;
   typedef enum logic [1:0] {ACF_SEL_MAIN, ACF_SEL_AUX} acf_sel_e;
   typedef enum logic [2:0] {
      ACF_ST_IDLE, ACF_ST_STATUS, ACF_ST_DATA, ACF_ST_CHECK
   } acf_state_e;
endpackage

// ### tb/acf_host.sv
`timescale 1ns/1ns
module acf_host (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic busy,
   input wire logic sdo,
   input wire logic byte_last,
   input wire logic slow,
   output logic shift,
   output logic [7:0] rx_byte,
   output logic [7:0] rx_last,
   output logic rx_stb
);
   logic [7:0] acc = 8'h00;
   logic [7:0] acc_last = 8'h00;
   logic take;
   int nbit = 0;
   // Bits are taken on the falling edge, half a cycle clear of the update;
   // each output is assigned once per edge so no glitch reaches the block
   always @(negedge clock) begin
      take = rst_n && busy === 1'b1 && !(slow && $urandom_range(1, 0));
      if (take) begin
         acc = {acc[6:0], sdo};
         acc_last = {acc_last[6:0], byte_last};
         nbit = nbit + 1;
      end else if (!rst_n || busy !== 1'b1) begin
         nbit = 0;
      end
      shift <= take;
      rx_stb <= take && nbit == 8;
      if (take && nbit == 8) begin
         rx_byte <= acc;
         rx_last <= acc_last;
         nbit = 0;
      end
   end
endmodule

// ### tb/adc_output_code_format_test.sv
`timescale 1ns/1ns
`include "acf_defs.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
   num_errors++; $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module adc_output_code_format_test;
   import acf_pkg::*;
   logic clock = 0, rst_n = 0, main_valid = 0, aux_valid = 0, start = 0;
   logic status_en = 0, check_en = 0, slow = 0, shift, sdo, busy, rx_stb;
   logic signed [39:0] main_raw = 0, aux_raw = 0;
   logic signed [39:0] vals [8] = '{0, 1, -1, 40'sh7f00000000,
      -40'sh7f00000000, 40'sh007fffffff, 40'sh0080000000, 40'sh0000800000};
   acf_sel_e sel = ACF_SEL_MAIN;
   logic [7:0] status_byte = 8'h00, check_byte = 8'h00, rx_byte, exp_b;
   logic [31:0] main_word, mexp;
   logic [23:0] aux_word, aexp;
   logic byte_last;
   logic [7:0] rx_last;
   logic [47:0] rx_hist = '0;
   logic timed_out = 1'b0;
   logic [7:0] expq [$];
   int num_errors = 0, n_checks = 0;
   always #4 clock = ~clock;
   acf_formatter dut_u (.clock(clock), .rst_n(rst_n),
      .main_valid(main_valid), .main_raw(main_raw), .aux_valid(aux_valid),
      .aux_raw(aux_raw), .start(start), .sel(sel), .status_en(status_en),
      .check_en(check_en), .status_byte(status_byte),
      .check_byte(check_byte), .shift(shift), .sdo(sdo), .busy(busy),
      .byte_last(byte_last), .main_word(main_word), .aux_word(aux_word));
   acf_host host_u (.clock(clock), .rst_n(rst_n), .busy(busy), .sdo(sdo),
      .byte_last(byte_last), .slow(slow), .shift(shift), .rx_byte(rx_byte),
      .rx_last(rx_last), .rx_stb(rx_stb));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] sat_main(logic signed [39:0] v);
      if (v > 40'sh007fffffff) return `ACF_MAIN_MAX;
      if (v < -40'sh0080000000) return `ACF_MAIN_MIN;
      return v[31:0];
   endfunction
   function automatic logic [23:0] sat_aux(logic signed [39:0] v);
      if (v > 40'sh00007fffff) return `ACF_AUX_MAX;
      if (v < -40'sh0000800000) return `ACF_AUX_MIN;
      return v[23:0];
   endfunction
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic load(input logic signed [39:0] v);
      @(negedge clock);
      main_raw = v;
      aux_raw = v;
      main_valid = 1'b1;
      aux_valid = 1'b1;
      @(negedge clock);
      main_valid = 1'b0;
      aux_valid = 1'b0;
      mexp = sat_main(v);
      aexp = sat_aux(v);
      @(negedge clock);
      `CHK("main_word", mexp, main_word)
      `CHK("aux_word", aexp, aux_word)
   endtask
   task automatic run_frame(input acf_sel_e s, input logic se, ce);
      logic [31:0] d;
      logic [31:0] w;
      int k;
      if (timed_out) return;
      d = (s == ACF_SEL_MAIN) ? mexp : {aexp, `ACF_PAD_BYTE};
      if (se) expq.push_back(status_byte);
      for (k = 3; k >= 0; k--) expq.push_back(d[k*8 +: 8]);
      if (ce) expq.push_back(check_byte);
      sel = s;
      status_en = se;
      check_en = ce;
      start = 1'b1;
      @(negedge clock);
      start = 1'b0;
      `CHK("busy", 1'b1, busy)
      for (k = 0; k < 1000 && busy !== 1'b0; k++) @(negedge clock);
      if (k == 1000) begin
         num_errors++;
         $display("MISMATCH busy exp 0 got %b", busy);
         timed_out = 1'b1;
      end
      `CHK("bytes_left", 0, expq.size())
      if (s == ACF_SEL_MAIN) begin
         // Host-side 24-bit use keeps only the three leading data bytes
         w = ce ? rx_hist[39:8] : rx_hist[31:0];
         `CHK("main_trunc24", mexp[31:8], w[31:8])
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Only frame bytes pass here; the queue order is the wire order
   always @(posedge clock) begin
      if (rx_stb === 1'b1) begin
         exp_b = (expq.size() > 0) ? expq.pop_front() : 8'hxx;
         `CHK("frame_byte", exp_b, rx_byte)
         `CHK("byte_last", 8'h01, rx_last)
         rx_hist = {rx_hist[39:0], rx_byte};
      end
   end
   initial begin
      void'($urandom(75));
      repeat (4) @(posedge clock);
      @(negedge clock);
      rst_n = 1'b1;
      `CHK("main_rst", `ACF_DATA_RST, main_word)
      `CHK("aux_rst", `ACF_AUX_ZERO, aux_word)
      vals[7] = 40'({$urandom, $urandom});
      foreach (vals[i]) begin
         load(vals[i]);
         status_byte = 8'($urandom);
         check_byte = 8'($urandom);
         slow = i[0];
         run_frame(ACF_SEL_MAIN, i[1], i[2]);
         run_frame(ACF_SEL_AUX, i[2], i[1]);
         $display("test %0d done", i);
      end
      // Mid-run reset clears the held words; a frame starts at once after
      @(negedge clock);
      rst_n = 1'b0;
      @(negedge clock);
      `CHK("main_rst2", `ACF_DATA_RST, main_word)
      `CHK("aux_rst2", `ACF_AUX_ZERO, aux_word)
      `CHK("busy_rst2", 1'b0, busy)
      rst_n = 1'b1;
      mexp = `ACF_DATA_RST;
      run_frame(ACF_SEL_MAIN, 1'b1, 1'b1);
      $display("test reset done");
      tally_and_finish;
   end
endmodule
